// >>> design/pms_sequencer.sv
// Purpose: Periodic measure, store and uplink sequencer of a battery remote logger.
// Assumes: Sensor, barometer and radio are driven through request and done handshakes; record memory takes a write strobe with no done.
// Notes: secondTick and usbPresent are asynchronous pins and are synchronised here.
`timescale 1ns/1ps
`include "pms_regs.svh"

module pms_sequencer
  import pms_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `PMS_CLK_HZ / `PMS_MS_PER_S,
  parameter int unsigned REC_AW = 15
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic secondTick,
  input wire logic usbPresent,
  input wire logic cfgWrite,
  input wire logic [15:0] cfgPeriod,
  input wire logic cfgDefault,
  output logic cfgStore,
  output logic [15:0] measurePeriod,
  output logic sensorPower,
  output logic readReq,
  output logic readRs485,
  input wire logic readDone,
  input wire logic readOk,
  input wire logic [31:0] readData,
  input wire logic baroEnable,
  output logic baroReq,
  input wire logic baroDone,
  input wire logic [31:0] baroData,
  output logic recWrite,
  output logic [REC_AW-1:0] recAddr,
  output logic [1:0] recKind,
  output logic [31:0] recData,
  input wire logic joined,
  output logic joinReq,
  input wire logic joinDone,
  input wire logic joinOk,
  output logic txReq,
  output logic [1:0] txSensorOk,
  input wire logic txDone,
  output logic rx1Open,
  output logic rx2Open,
  input wire logic downlinkIn,
  input wire logic [31:0] downlinkInData,
  output logic downlinkValid,
  output logic [31:0] downlinkData,
  output logic status_lamp_one,
  output logic activeMode,
  output logic wake,
  output logic busy,
  input wire logic battValid,
  input wire logic [11:0] battMv,
  input wire logic capDecrement,
  output logic [6:0] capacity
);

  localparam logic [15:0] PERIOD_DEFAULT = 16'(`PMS_PERIOD_DEFAULT_MIN * `PMS_SEC_PER_MIN);
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  typedef struct packed {
    logic usbMeta;
    logic usbSync;
    logic tickMeta;
    logic tickSync;
    logic tickPrev;
    pms_state_t state;
    logic [15:0] period;
    logic [15:0] secCount;
    logic pending;
    logic [2:0] secMod;
    logic rs485;
    logic [1:0] tries;
    logic sensorOk;
    logic [1:0] joinTries;
    logic [15:0] msDiv;
    logic [15:0] rxMs;
    logic [7:0] flashMs;
    logic [REC_AW-1:0] recPtr;
    logic [31:0] sensorVal;
    logic [31:0] baroVal;
    logic baroOk;
    logic readReq;
    logic baroReq;
    logic recWrite;
    logic [1:0] recKind;
    logic [31:0] recData;
    logic joinReq;
    logic txReq;
    logic dlValid;
    logic [31:0] dlData;
    logic cfgStore;
    logic wake;
    logic [6:0] capacity;
    logic [11:0] lastMv;
  } pms_seq_t;

  pms_seq_t s;
  pms_seq_t next_s;
  logic msTick;
  logic delayStart;
  logic delayDone;

  function automatic logic [11:0] absDiff(input logic [11:0] a, input logic [11:0] b);
    absDiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic msReached(input logic [15:0] count, input int unsigned limit);
    msReached = (count >= 16'(limit));
  endfunction

  assign msTick = (s.msDiv == MS_LAST);
  assign delayStart = (s.state == PMS_STORE_BARO);

  pms_random_delay u_delay
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .msTick(msTick),
    .start(delayStart),
    .done(delayDone),
    .busy()
  );

  always_comb
  begin
    logic tickEdge;
    logic expire;
    tickEdge = 1'b0;
    expire = 1'b0;
    next_s = s;
    next_s.usbMeta = usbPresent;
    next_s.usbSync = s.usbMeta;
    next_s.tickMeta = secondTick;
    next_s.tickSync = s.tickMeta;
    next_s.tickPrev = s.tickSync;
    tickEdge = s.tickSync & ~s.tickPrev;
    expire = tickEdge && (s.secCount + 16'h1 >= s.period);
    next_s.readReq = 1'b0;
    next_s.baroReq = 1'b0;
    next_s.recWrite = 1'b0;
    next_s.joinReq = 1'b0;
    next_s.txReq = 1'b0;
    next_s.dlValid = 1'b0;
    next_s.cfgStore = 1'b0;
    next_s.wake = tickEdge;
    next_s.msDiv = msTick ? 16'h0 : s.msDiv + 16'h1;
    if (msTick && s.flashMs != 8'h0)
    begin
      next_s.flashMs = s.flashMs - 8'h1;
    end

    // Configuration writes go straight out to non-volatile storage as well.
    if (cfgDefault)
    begin
      next_s.period = PERIOD_DEFAULT;
      next_s.cfgStore = 1'b1;
    end
    else if (cfgWrite)
    begin
      next_s.period = cfgPeriod;
      next_s.cfgStore = 1'b1;
    end

    if (tickEdge)
    begin
      next_s.secMod = (s.secMod == 3'(`PMS_SLEEP_FLASH_S - 1)) ? 3'h0 : s.secMod + 3'h1;
      if (s.usbSync || s.secMod == 3'h0)
      begin
        next_s.flashMs = 8'(`PMS_FLASH_MS);
      end
      // The period keeps running during a cycle so the schedule does not drift.
      if (expire)
      begin
        next_s.secCount = 16'h0;
        next_s.pending = 1'b1;
      end
      else
      begin
        next_s.secCount = s.secCount + 16'h1;
      end
    end

    if (battValid && absDiff(battMv, s.lastMv) > 12'(`PMS_CAP_RESET_MV))
    begin
      next_s.capacity = 7'(`PMS_CAP_FULL_PCT);
      next_s.lastMv = battMv;
    end
    else if (capDecrement && s.capacity != 7'h0)
    begin
      next_s.capacity = s.capacity - 7'h1;
    end

    case (s.state)
      PMS_IDLE:
      begin
        if (s.pending)
        begin
          // A period that ends in the same cycle as the start must not be lost.
          next_s.pending = expire;
          next_s.rs485 = 1'b0;
          next_s.tries = 2'h0;
          next_s.state = PMS_READ_REQ;
        end
      end
      PMS_READ_REQ:
      begin
        next_s.readReq = 1'b1;
        next_s.state = PMS_READ_WAIT;
      end
      PMS_READ_WAIT:
      begin
        if (readDone)
        begin
          if (readOk)
          begin
            next_s.sensorOk = 1'b1;
            next_s.sensorVal = readData;
            next_s.baroReq = baroEnable;
            next_s.state = PMS_BARO_WAIT;
          end
          else if (s.tries != 2'(`PMS_READ_TRIES - 1))
          begin
            next_s.tries = s.tries + 2'h1;
            next_s.state = PMS_READ_REQ;
          end
          else if (!s.rs485)
          begin
            next_s.rs485 = 1'b1;
            next_s.tries = 2'h0;
            next_s.state = PMS_READ_REQ;
          end
          else
          begin
            next_s.sensorOk = 1'b0;
            next_s.baroReq = baroEnable;
            next_s.state = PMS_BARO_WAIT;
          end
        end
      end
      PMS_BARO_WAIT:
      begin
        next_s.baroOk = 1'b0;
        if (!baroEnable && !s.baroReq)
        begin
          next_s.state = PMS_STORE_SENSOR;
        end
        else if (baroDone)
        begin
          next_s.baroOk = 1'b1;
          next_s.baroVal = baroData;
          next_s.state = PMS_STORE_SENSOR;
        end
      end
      PMS_STORE_SENSOR:
      begin
        if (s.sensorOk)
        begin
          next_s.recWrite = 1'b1;
          next_s.recKind = `PMS_KIND_SENSOR;
          next_s.recData = s.sensorVal;
          next_s.recPtr = s.recPtr + 1'b1;
        end
        next_s.state = PMS_STORE_BARO;
      end
      PMS_STORE_BARO:
      begin
        if (s.baroOk)
        begin
          next_s.recWrite = 1'b1;
          next_s.recKind = `PMS_KIND_BARO;
          next_s.recData = s.baroVal;
          next_s.recPtr = s.recPtr + 1'b1;
        end
        next_s.joinTries = 2'h0;
        next_s.state = PMS_DELAY;
      end
      PMS_DELAY:
      begin
        if (delayDone)
        begin
          next_s.joinReq = ~joined;
          next_s.txReq = joined;
          next_s.state = joined ? PMS_TX_WAIT : PMS_JOIN_WAIT;
        end
      end
      PMS_JOIN_WAIT:
      begin
        if (joinDone)
        begin
          if (joinOk)
          begin
            next_s.txReq = 1'b1;
            next_s.state = PMS_TX_WAIT;
          end
          else if (s.joinTries != 2'(`PMS_JOIN_TRIES - 1))
          begin
            next_s.joinTries = s.joinTries + 2'h1;
            next_s.joinReq = 1'b1;
          end
          else
          begin
            next_s.state = PMS_IDLE;
          end
        end
      end
      PMS_TX_WAIT:
      begin
        next_s.rxMs = 16'h0;
        if (txDone)
        begin
          next_s.state = PMS_RX1_DELAY;
        end
      end
      PMS_RX1_DELAY, PMS_RX1_OPEN, PMS_RX2_DELAY, PMS_RX2_OPEN:
      begin
        if (msTick)
        begin
          next_s.rxMs = s.rxMs + 16'h1;
        end
        if ((s.state == PMS_RX1_OPEN || s.state == PMS_RX2_OPEN) && downlinkIn)
        begin
          next_s.dlValid = 1'b1;
          next_s.dlData = downlinkInData;
        end
        if ((s.state == PMS_RX1_DELAY && msReached(s.rxMs, `PMS_RX1_DELAY_MS))
          || (s.state == PMS_RX2_DELAY && msReached(s.rxMs, `PMS_RX2_DELAY_MS))
          || (s.state != PMS_RX1_DELAY && s.state != PMS_RX2_DELAY && msReached(s.rxMs, `PMS_RX_WIN_MS)))
        begin
          next_s.rxMs = 16'h0;
          case (s.state)
            PMS_RX1_DELAY: next_s.state = PMS_RX1_OPEN;
            PMS_RX1_OPEN: next_s.state = PMS_RX2_DELAY;
            PMS_RX2_DELAY: next_s.state = PMS_RX2_OPEN;
            default: next_s.state = PMS_IDLE;
          endcase
        end
      end
      default:
      begin
        next_s.state = PMS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.state <= PMS_IDLE;
      s.period <= PERIOD_DEFAULT;
      s.capacity <= 7'(`PMS_CAP_FULL_PCT);
    end
    else
    begin
      s <= next_s;
    end
  end

  assign cfgStore = s.cfgStore;
  assign measurePeriod = s.period;
  // Power stays on across retries and interface changes and drops once reading ends.
  assign sensorPower = (s.state == PMS_READ_REQ) || (s.state == PMS_READ_WAIT);
  assign readReq = s.readReq;
  assign readRs485 = s.rs485;
  assign baroReq = s.baroReq;
  assign recWrite = s.recWrite;
  assign recAddr = s.recPtr - 1'b1;
  assign recKind = s.recKind;
  assign recData = s.recData;
  assign joinReq = s.joinReq;
  assign txReq = s.txReq;
  assign txSensorOk = {s.baroOk, s.sensorOk};
  assign rx1Open = (s.state == PMS_RX1_OPEN);
  assign rx2Open = (s.state == PMS_RX2_OPEN);
  assign downlinkValid = s.dlValid;
  assign downlinkData = s.dlData;
  assign status_lamp_one = (s.flashMs != 8'h0);
  assign activeMode = s.usbSync;
  assign wake = s.wake;
  assign busy = (s.state != PMS_IDLE);
  assign capacity = s.capacity;

endmodule

// >>> design/pms_regs.svh
// Purpose: Named constants for the periodic measure sequencer.
// Assumes: A 40 MHz system clock and a one-second tick from the real-time clock.
// Notes: Times are kept in their own units; cycle counts are derived in the modules.
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

`define PMS_CLK_HZ 40000000
`define PMS_MS_PER_S 1000
`define PMS_SEC_PER_MIN 60
`define PMS_PERIOD_DEFAULT_MIN 30
`define PMS_READ_TRIES 3
`define PMS_JOIN_TRIES 3
`define PMS_TX_DELAY_MAX_S 6
`define PMS_SLEEP_FLASH_S 5
`define PMS_FLASH_MS 50
`define PMS_RX1_DELAY_MS 1000
`define PMS_RX2_DELAY_MS 1000
`define PMS_RX_WIN_MS 100
`define PMS_CAP_FULL_PCT 99
`define PMS_CAP_RESET_MV 300
`define PMS_LFSR_SEED 16'hace1
`define PMS_KIND_SENSOR 2'h1
`define PMS_KIND_BARO 2'h2

`endif

// >>> design/pms_pkg.sv
// Purpose: Shared types of the periodic measure sequencer.
// Assumes: Nothing beyond the constants header.
// Notes: Only types live here.
package pms_pkg;

  typedef enum logic [3:0] {
    PMS_IDLE,
    PMS_READ_REQ,
    PMS_READ_WAIT,
    PMS_BARO_WAIT,
    PMS_STORE_SENSOR,
    PMS_STORE_BARO,
    PMS_DELAY,
    PMS_JOIN_WAIT,
    PMS_TX_WAIT,
    PMS_RX1_DELAY,
    PMS_RX1_OPEN,
    PMS_RX2_DELAY,
    PMS_RX2_OPEN
  } pms_state_t;

endpackage

// >>> design/pms_random_delay.sv
// Purpose: Random transmit hold-off of 0 to 6 seconds in whole milliseconds.
// Assumes: msTick is a one-cycle pulse once per millisecond on sys_clk.
// Notes: The generator steps every cycle whether or not a delay is running.
`timescale 1ns/1ps
`include "pms_regs.svh"

module pms_random_delay
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic msTick,
  input wire logic start,
  output logic done,
  output logic busy
);

  localparam logic [12:0] MAX_MS = 13'(`PMS_TX_DELAY_MAX_S * `PMS_MS_PER_S);

  typedef struct packed {
    logic [15:0] lfsr;
    logic draw;
    logic active;
    logic [12:0] remain;
    logic done;
  } pms_rd_t;

  pms_rd_t s;
  pms_rd_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
    if (s.draw)
    begin
      // Rejecting draws above the maximum keeps every accepted value equally likely.
      if (s.lfsr[12:0] <= MAX_MS)
      begin
        next_s.remain = s.lfsr[12:0];
        next_s.draw = 1'b0;
        next_s.active = 1'b1;
      end
    end
    else if (s.active)
    begin
      if (s.remain == 13'h0)
      begin
        next_s.active = 1'b0;
        next_s.done = 1'b1;
      end
      else if (msTick)
      begin
        next_s.remain = s.remain - 13'h1;
      end
    end
    else if (start)
    begin
      next_s.draw = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s <= '{lfsr: `PMS_LFSR_SEED, draw: 1'b0, active: 1'b0, remain: 13'h0, done: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign busy = s.draw | s.active;

endmodule

// >>> dv/pms_sequencer_chk.sv
// Purpose: Concurrent checks on the sequencer's ports.
// Assumes: Bound into every pms_sequencer instance.
// Notes: Attempt counters clear whenever the sequencer is idle.
`timescale 1ns/1ps
module pms_sequencer_chk
#(
  parameter int unsigned REC_AW = 15
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cfgWrite,
  input wire logic cfgDefault,
  input wire logic cfgStore,
  input wire logic sensorPower,
  input wire logic readReq,
  input wire logic readRs485,
  input wire logic busy,
  input wire logic joined,
  input wire logic joinReq,
  input wire logic joinDone,
  input wire logic joinOk,
  input wire logic txReq,
  input wire logic recWrite,
  input wire logic [REC_AW-1:0] recAddr,
  input wire logic rx1Open,
  input wire logic rx2Open,
  input wire logic downlinkIn,
  input wire logic [31:0] downlinkInData,
  input wire logic downlinkValid,
  input wire logic [31:0] downlinkData,
  input wire logic battValid,
  input wire logic [6:0] capacity
);
  logic [2:0] i2cCnt;
  logic [2:0] joinCnt;
  logic gotJoin;
  logic [REC_AW-1:0] lastAddr;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !busy)
    begin
      i2cCnt <= 3'h0;
      joinCnt <= 3'h0;
      gotJoin <= 1'b0;
    end
    else
    begin
      i2cCnt <= i2cCnt + {2'h0, readReq && !readRs485};
      joinCnt <= joinCnt + {2'h0, joinReq};
      gotJoin <= gotJoin || (joinDone && joinOk);
    end
    if (sys_rst)
      lastAddr <= '1;
    else if (recWrite)
      lastAddr <= recAddr;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  power_read_a: assert property (readReq |-> sensorPower)
    else $error("read request without sensor power");
  power_idle_a: assert property (!busy |-> !sensorPower)
    else $error("sensor powered while idle");
  i2c_limit_a: assert property (i2cCnt <= 3'h3)
    else $error("too many bus attempts");
  rs485_order_a: assert property (readReq && readRs485 |-> i2cCnt == 3'h3)
    else $error("serial link tried before three bus attempts");
  join_limit_a: assert property (joinCnt <= 3'h3)
    else $error("too many join attempts");
  tx_joined_a: assert property (txReq |-> joined || gotJoin)
    else $error("uplink without network join");
  dl_accept_a: assert property (downlinkIn && (rx1Open || rx2Open) |=> downlinkValid && downlinkData == $past(downlinkInData))
    else $error("downlink in window not delivered");
  dl_ignore_a: assert property (downlinkIn && !rx1Open && !rx2Open |=> !downlinkValid)
    else $error("downlink outside window delivered");
  cfg_store_a: assert property (cfgWrite || cfgDefault |=> cfgStore)
    else $error("configuration not stored");
  ring_step_a: assert property (recWrite |-> recAddr == REC_AW'(lastAddr + 1'b1))
    else $error("record address skipped");
  cap_reset_a: assert property (capacity > $past(capacity) |-> capacity == 7'h63 && $past(battValid))
    else $error("capacity rose without reset to full");
endmodule

bind pms_sequencer pms_sequencer_chk #(.REC_AW(REC_AW)) pms_sequencer_chk_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cfgWrite(cfgWrite), .cfgDefault(cfgDefault), .cfgStore(cfgStore),
  .sensorPower(sensorPower), .readReq(readReq), .readRs485(readRs485), .busy(busy), .joined(joined),
  .joinReq(joinReq), .joinDone(joinDone), .joinOk(joinOk), .txReq(txReq), .recWrite(recWrite),
  .recAddr(recAddr), .rx1Open(rx1Open), .rx2Open(rx2Open), .downlinkIn(downlinkIn),
  .downlinkInData(downlinkInData), .downlinkValid(downlinkValid), .downlinkData(downlinkData),
  .battValid(battValid), .capacity(capacity));

// >>> dv/pms_sensor_model.sv
// Purpose: Behavioural pressure sensor answering read attempts.
// Assumes: Attempts count from power-up; the first failCount of them fail.
// Notes: An unpowered sensor never answers, and its data toggles when not answering.
`timescale 1ns/1ps
module pms_sensor_model
#(
  parameter logic [7:0] LINK_ADDR = 8'hfa,
  parameter logic [6:0] BUS_ADDR = 7'h40,
  parameter logic [31:0] VALUE = 32'h1234abcd
)
(
  input wire logic sys_clk,
  input wire logic sensorPower,
  input wire logic readReq,
  input wire logic [2:0] failCount,
  input wire logic slow,
  output logic readDone,
  output logic readOk,
  output logic [31:0] readData
);
  int attempt = 0;
  int waitCnt = 0;

  initial
  begin
    readDone = 1'b0;
    readOk = 1'b0;
    readData = 32'h0;
  end

  always @(posedge sys_clk)
  begin
    #1;
    readDone <= 1'b0;
    readOk <= 1'b0;
    readData <= ~readData;
    if (sensorPower !== 1'b1)
    begin
      attempt = 0;
      waitCnt = 0;
    end
    else if (readReq === 1'b1)
      waitCnt = slow ? 20 : 1;
    else if (waitCnt > 0)
    begin
      waitCnt--;
      if (waitCnt == 0)
      begin
        readDone <= 1'b1;
        readOk <= attempt >= int'(failCount);
        if (attempt >= int'(failCount))
          readData <= VALUE;
        attempt++;
      end
    end
  end
endmodule

// >>> dv/periodic_measure_sequencer_test.sv
// Purpose: Self-checking bench of the periodic measure sequencer.
// Assumes: A millisecond is shortened to four cycles and the record ring to sixteen slots.
// Notes: Barometer and radio are answered by a responder here, one cycle after each request.
`timescale 1ns/1ps
module periodic_measure_sequencer_test;
  localparam int unsigned AW = 4;
  logic sys_clk, sys_rst, secondTick, usbPresent, cfgWrite, cfgDefault, baroEnable, baroDone, joined;
  logic joinDone, joinOk, txDone, downlinkIn, battValid, capDecrement, readDone, readOk, slow;
  logic cfgStore, sensorPower, readReq, readRs485, baroReq, recWrite, joinReq, txReq, lampPrev;
  logic rx1Open, rx2Open, downlinkValid, status_lamp_one, activeMode, wake, busy;
  logic [15:0] cfgPeriod, measurePeriod;
  logic [31:0] readData, baroData, recData, downlinkInData, downlinkData;
  logic [AW-1:0] recAddr;
  logic [1:0] recKind, txSensorOk;
  logic [11:0] battMv;
  logic [6:0] capacity;
  logic [2:0] failCount;
  int error_cnt, num_checks, cyc, i2cN, rsN, senRec, baroRec, recTotal, joinCnt, joinFails, txCnt;
  int lampN, wakeN, txAt, lastRec;

  pms_sequencer #(.MS_CYCLES(4), .REC_AW(AW)) pms_sequencer_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .secondTick(secondTick), .usbPresent(usbPresent),
    .cfgWrite(cfgWrite), .cfgPeriod(cfgPeriod), .cfgDefault(cfgDefault), .cfgStore(cfgStore),
    .measurePeriod(measurePeriod), .sensorPower(sensorPower), .readReq(readReq), .readRs485(readRs485),
    .readDone(readDone), .readOk(readOk), .readData(readData), .baroEnable(baroEnable), .baroReq(baroReq),
    .baroDone(baroDone), .baroData(baroData), .recWrite(recWrite), .recAddr(recAddr), .recKind(recKind),
    .recData(recData), .joined(joined), .joinReq(joinReq), .joinDone(joinDone), .joinOk(joinOk),
    .txReq(txReq), .txSensorOk(txSensorOk), .txDone(txDone), .rx1Open(rx1Open), .rx2Open(rx2Open),
    .downlinkIn(downlinkIn), .downlinkInData(downlinkInData), .downlinkValid(downlinkValid),
    .downlinkData(downlinkData), .status_lamp_one(status_lamp_one), .activeMode(activeMode), .wake(wake),
    .busy(busy), .battValid(battValid), .battMv(battMv), .capDecrement(capDecrement), .capacity(capacity));

  pms_sensor_model pms_sensor_model_i (
    .sys_clk(sys_clk), .sensorPower(sensorPower), .readReq(readReq), .failCount(failCount), .slow(slow),
    .readDone(readDone), .readOk(readOk), .readData(readData));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The worst case is two full random hold-offs plus both receive windows.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      error_cnt++;
      $display("BAD %0t run hung", $time);
      give_verdict();
    end
  end

  always @(posedge sys_clk)
  begin
    #1;
    baroDone <= baroReq;
    baroData <= baroReq ? 32'h00ba0001 : ~baroData;
    txDone <= txReq;
    joinDone <= joinReq;
    joinOk <= joinReq && joinCnt >= joinFails;
    if (joinReq === 1'b1)
      joinCnt++;
  end

  // Counting on the falling edge keeps it clear of the tasks, which act just after the rising edge.
  always @(negedge sys_clk)
  begin
    if (readReq === 1'b1)
      if (readRs485 === 1'b1)
        rsN++;
      else
        i2cN++;
    if (txReq === 1'b1)
      txCnt++;
    if (txReq === 1'b1)
      txAt = cyc;
    if (wake === 1'b1)
      wakeN++;
    if (status_lamp_one === 1'b1 && lampPrev !== 1'b1)
      lampN++;
    lampPrev = status_lamp_one;
    if (sensorPower === 1'b1)
      lastRec = cyc;
    if (recWrite === 1'b1)
    begin
      chk(recAddr === AW'(recTotal), "record address");
      chk(recKind !== 2'h1 || recData === 32'h1234abcd, "sensor record data");
      chk(recKind !== 2'h2 || recData === 32'h00ba0001, "baro record data");
      senRec += int'(recKind === 2'h1);
      baroRec += int'(recKind === 2'h2);
      recTotal++;
    end
  end

  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task tick();
    secondTick = 1'b1;
    step(2);
    secondTick = 1'b0;
    step(300);
  endtask

  task test_reset();
    chk(measurePeriod === 16'h0708, "default period");
    chk(capacity === 7'h63, "capacity after reset");
    chk(sensorPower === 1'b0 && busy === 1'b0, "not idle after reset");
  endtask

  task test_config();
    downlinkIn = 1'b1;
    step(1);
    downlinkIn = 1'b0;
    chk(downlinkValid === 1'b0, "downlink outside window");
    cfgPeriod = 16'h0258;
    cfgWrite = 1'b1;
    step(1);
    cfgWrite = 1'b0;
    chk(cfgStore === 1'b1, "no store after write");
    step(1);
    chk(measurePeriod === 16'h0258, "period not written");
    cfgDefault = 1'b1;
    cfgWrite = 1'b1;
    step(1);
    cfgDefault = 1'b0;
    cfgWrite = 1'b0;
    chk(cfgStore === 1'b1, "no store after default");
    step(1);
    chk(measurePeriod === 16'h0708, "default not restored");
  endtask

  task batt(input logic [11:0] mv, input logic v, input logic [6:0] expCap);
    battMv = mv;
    battValid = v;
    capDecrement = !v;
    step(1);
    battValid = 1'b0;
    capDecrement = 1'b0;
    step(1);
    chk(capacity === expCap, "capacity value");
  endtask

  task test_lamp();
    lampN = 0;
    wakeN = 0;
    repeat (10) tick();
    chk(lampN == 2, "sleep flash count");
    chk(wakeN == 10, "wake count");
    usbPresent = 1'b1;
    step(5);
    chk(activeMode === 1'b1, "not active with usb");
    lampN = 0;
    repeat (3) tick();
    chk(lampN == 3, "active flash count");
    usbPresent = 1'b0;
  endtask

  task automatic test_measure(input int fails, input logic sl, input logic jn, input logic bo, input int expRs,
                              input int expJoin);
    int n;
    failCount = 3'(fails);
    slow = sl;
    joined = jn;
    baroEnable = bo;
    {i2cN, rsN, senRec, baroRec, joinCnt, txCnt} = '0;
    cfgPeriod = 16'h0001;
    cfgWrite = 1'b1;
    step(1);
    cfgWrite = 1'b0;
    lastRec = cyc;
    tick();
    for (n = 0; txCnt == 0 && n < 26000; n++)
      step(1);
    chk(sensorPower === 1'b0, "sensor still powered");
    chk(txCnt == 1, "no single uplink");
    chk(i2cN == 3 && rsN == expRs, "read attempt counts");
    chk(senRec == int'(fails < 6) && baroRec == int'(bo), "record counts");
    chk(txSensorOk === {bo, fails < 6}, "uplink status");
    chk(joinCnt == expJoin, "join attempts");
    chk(txAt - lastRec <= 24300, "hold-off too long");
    for (int w = 0; w < 2; w++)
    begin
      for (n = 0; (w == 0 ? rx1Open : rx2Open) !== 1'b1 && n < 5000; n++)
        step(1);
      downlinkInData = w == 0 ? 32'h5a5a0001 : 32'h5a5a0002;
      downlinkIn = 1'b1;
      step(1);
      downlinkIn = 1'b0;
      chk(downlinkValid === 1'b1 && downlinkData === downlinkInData, "downlink in window");
    end
    for (n = 0; busy !== 1'b0 && n < 5000; n++)
      step(1);
    chk(busy === 1'b0, "not back to idle");
  endtask

  initial
  begin
    {sys_rst, secondTick, usbPresent, cfgWrite, cfgDefault, baroEnable, joined} = 7'h40;
    {downlinkIn, battValid, capDecrement, slow, lampPrev} = 5'h0;
    {baroDone, joinDone, joinOk, txDone} = 4'h0;
    {cfgPeriod, battMv, failCount, baroData, downlinkInData} = '0;
    {error_cnt, num_checks, cyc, recTotal} = '0;
    joinFails = 2;
    step(10);
    sys_rst = 1'b0;
    step(1);
    test_reset();
    test_config();
    batt(12'hce4, 1'b1, 7'h63);
    batt(12'hce4, 1'b0, 7'h62);
    batt(12'he10, 1'b1, 7'h62);
    batt(12'hb54, 1'b1, 7'h63);
    test_lamp();
    test_measure(3, 1'b0, 1'b1, 1'b1, 1, 0);
    test_measure(6, 1'b1, 1'b0, 1'b0, 3, 3);
    give_verdict();
  end
endmodule
